// ### design/sagl_glue.sv
// Purpose: Glue between adapter microcontroller, serial controller,
//          modem pins and the system DMA controller
// Assumes: Register port from logic on clock; pins pass synchronisers
// Notes:   Controller register access passes straight to its pins
//
// Our own choices: the plain strobed port and the address map.
`include "sagl_params.svh"
`timescale 1ns/1ns
`default_nettype none

module sagl_glue #(
   parameter int ENC_W = `SAGL_DMA_ENC_W
) (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic             clk_en,
   input  wire logic [3:0]       reg_addr,
   input  wire logic [7:0]       reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic      [7:0]       reg_rdata,
   input  wire logic             ctl_wr5_rts_p1,
   input  wire logic             ctl_wr5_rts_p2,
   input  wire logic             ctl_dma_req_a,
   input  wire logic             ctl_int_n,
   input  wire logic [4:0]       p1_modem_in,
   input  wire logic [4:0]       p2_modem_in,
   input  wire logic [4:0]       p2_acu_in,
   input  wire logic             x21_indicate,
   input  wire logic             x21_rxd,
   input  wire logic             x21_clk_en,
   input  wire logic             p1_modem_rxc,
   input  wire logic             p1_modem_txc,
   input  wire logic             p2_modem_rxc,
   input  wire logic             p2_modem_txc,
   input  wire logic             chan_a_transmit_clock_pin,
   input  wire logic             dma_acknowledge,
   input  wire logic             terminal_count,
   output logic      [4:0]       p1_modem_out,
   output logic      [4:0]       p2_modem_out,
   output logic                  p2_acu_sel,
   output logic                  dma_request,
   output logic      [ENC_W-1:0] dma_channel,
   output logic                  chan_a_receive_clock_pin,
   output logic                  chan_a_tx_clock_in,
   output logic                  chan_b_receive_clock_pin,
   output logic                  chan_b_tx_clock_in,
   output logic                  biphase_tx_clock
);

   // Decode of register write strobes
   function automatic logic wr_hit(input logic [3:0] a,
                                   input logic [3:0] off);
      wr_hit = (a == off);
   endfunction

   logic [7:0] p1_ctrl1_reg;
   logic [7:0] p1_ctrl2_reg;
   logic [7:0] p2_ctrl1_reg;
   logic [7:0] p2_ctrl2_reg;
   logic [7:0] wrap_reg;
   logic [7:0] dma_ctrl_reg;
   logic [7:0] p1_modem_reg;
   logic [7:0] p2_modem_reg;
   logic       reg_rd_d_reg;
   logic       ack_latch_reg;
   logic       tc_latch_reg;
   logic [1:0] x21_hist_reg;
   logic [4:0] biph_cnt_reg;
   sagl_pkg::sagl_dma_state_t dma_state_reg;

   // Two-flop synchronisers for every pin input except the unused controller DMA request and interrupt pins
   localparam int NSYNC = 27;
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] sync1_reg;
   logic [NSYNC-1:0] sync2_reg;
   assign pin_raw = {p1_modem_in, p2_modem_in, p2_acu_in, x21_indicate,
                     x21_rxd, x21_clk_en, p1_modem_rxc, p1_modem_txc,
                     p2_modem_rxc, p2_modem_txc,
                     chan_a_transmit_clock_pin, dma_acknowledge,
                     terminal_count, ctl_wr5_rts_p1, ctl_wr5_rts_p2};

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               sync1_reg[gi] <= 1'b0;
               sync2_reg[gi] <= 1'b0;
            end else if (clk_en) begin
               sync1_reg[gi] <= pin_raw[gi];
               sync2_reg[gi] <= sync1_reg[gi];
            end
         end
      end
   endgenerate

   logic [4:0] s_p1_in;
   logic [4:0] s_p2_in;
   logic [4:0] s_acu;
   logic       s_x21_ind;
   logic       s_x21_rxd;
   logic       s_x21_en;
   logic       s_p1_rxc;
   logic       s_p1_txc;
   logic       s_p2_rxc;
   logic       s_p2_txc;
   logic       s_ctl_txc;
   logic       s_ack;
   logic       s_tc;
   logic       s_rts1;
   logic       s_rts2;
   assign {s_p1_in, s_p2_in, s_acu, s_x21_ind, s_x21_rxd, s_x21_en,
           s_p1_rxc, s_p1_txc, s_p2_rxc, s_p2_txc, s_ctl_txc, s_ack,
           s_tc, s_rts1, s_rts2} = sync2_reg;

   // Control registers written by firmware
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         p1_ctrl1_reg <= `SAGL_RESET_BYTE;
         p1_ctrl2_reg <= `SAGL_RESET_BYTE;
         p2_ctrl1_reg <= `SAGL_RESET_BYTE;
         p2_ctrl2_reg <= `SAGL_RESET_BYTE;
         wrap_reg     <= `SAGL_RESET_BYTE;
         dma_ctrl_reg <= `SAGL_RESET_BYTE;
      end else if (clk_en && reg_wr) begin
         if (wr_hit(reg_addr, `SAGL_OFF_P1_CTRL1))
            p1_ctrl1_reg <= reg_wdata;
         if (wr_hit(reg_addr, `SAGL_OFF_P1_CTRL2))
            p1_ctrl2_reg <= reg_wdata;
         if (wr_hit(reg_addr, `SAGL_OFF_P2_CTRL1))
            p2_ctrl1_reg <= reg_wdata;
         if (wr_hit(reg_addr, `SAGL_OFF_P2_CTRL2))
            p2_ctrl2_reg <= reg_wdata;
         if (wr_hit(reg_addr, `SAGL_OFF_WRAP))
            wrap_reg <= reg_wdata;
         if (wr_hit(reg_addr, `SAGL_OFF_DMA_CTRL))
            dma_ctrl_reg <= reg_wdata;
      end
   end

   // Outgoing control lines; only RTS merges the controller bit
   logic [4:0] p1_out_next;
   logic [4:0] p2_out_next;
   always_comb begin
      p1_out_next = p1_ctrl1_reg[4:0];
      p2_out_next = p2_ctrl1_reg[4:0];
      p1_out_next[`SAGL_CTRL1_RTS] = p1_ctrl1_reg[`SAGL_CTRL1_RTS]
                                     | s_rts1;
      p2_out_next[`SAGL_CTRL1_RTS] = p2_ctrl1_reg[`SAGL_CTRL1_RTS]
                                     | s_rts2;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         p1_modem_out <= 5'h00;
         p2_modem_out <= 5'h00;
         p2_acu_sel   <= 1'b0;
      end else if (clk_en) begin
         p1_modem_out <= p1_out_next;
         p2_modem_out <= p2_out_next;
         p2_acu_sel   <= p2_ctrl2_reg[`SAGL_CTRL2_ACU];
      end
   end

   // Wrap multiplexing and inversion of modem status
   logic       wrap_on;
   logic [4:0] p1_src;
   logic [4:0] p2_src;
   logic [4:0] acu_src;
   assign wrap_on = wrap_reg[`SAGL_WRAP_DRV] | wrap_reg[`SAGL_WRAP_RCV];
   assign p1_src  = wrap_on ? p1_out_next : s_p1_in;
   assign p2_src  = wrap_on ? p2_out_next : s_p2_in;
   assign acu_src = wrap_on ? p2_out_next : s_acu;

   // Port 2 lines or calling unit, picked by the mode select bit
   logic [4:0] p2_pick;
   logic [7:0] p1_live;
   logic [7:0] p2_live;
   assign p2_pick = p2_ctrl2_reg[`SAGL_CTRL2_ACU] ? acu_src
                                                   : p2_src;
   assign p1_live = {3'h0, ~p1_src};
   assign p2_live = {~s_x21_ind, x21_hist_reg, ~p2_pick};

   // Capture on leading edge of the read strobe
   logic rd_lead;
   assign rd_lead = reg_rd & ~reg_rd_d_reg;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         reg_rd_d_reg <= 1'b0;
         p1_modem_reg <= `SAGL_RESET_BYTE;
         p2_modem_reg <= `SAGL_RESET_BYTE;
      end else if (clk_en) begin
         reg_rd_d_reg <= reg_rd;
         if (rd_lead) begin
            p1_modem_reg <= p1_live;
            p2_modem_reg <= p2_live;
         end
      end
   end

   // Received X.21 data history, kept only while clock logic is enabled
   logic s_x21_clk_d_reg;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         x21_hist_reg    <= 2'h0;
         s_x21_clk_d_reg <= 1'b0;
      end else if (clk_en) begin
         s_x21_clk_d_reg <= s_p2_rxc;
         if (!s_x21_en)
            x21_hist_reg <= 2'h0;
         else if (s_p2_rxc && !s_x21_clk_d_reg)
            x21_hist_reg <= {x21_hist_reg[0], s_x21_rxd};
      end
   end

   // DMA request handshake
   logic dma_en;
   logic s_ack_d_reg;
   logic s_tc_d_reg;
   logic ack_rise;
   logic tc_rise;
   assign dma_en   = dma_ctrl_reg[`SAGL_DMA_EN];
   assign ack_rise = s_ack & ~s_ack_d_reg;
   assign tc_rise  = s_tc & ~s_tc_d_reg;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         dma_state_reg <= sagl_pkg::SAGL_DMA_IDLE;
         s_ack_d_reg   <= 1'b0;
         s_tc_d_reg    <= 1'b0;
      end else if (clk_en) begin
         s_ack_d_reg <= s_ack;
         s_tc_d_reg  <= s_tc;
         unique case (dma_state_reg)
            sagl_pkg::SAGL_DMA_IDLE: begin
               if (dma_en)
                  dma_state_reg <= sagl_pkg::SAGL_DMA_REQ;
            end
            sagl_pkg::SAGL_DMA_REQ: begin
               if (!dma_en)
                  dma_state_reg <= sagl_pkg::SAGL_DMA_IDLE;
               else if (ack_rise)
                  dma_state_reg <= sagl_pkg::SAGL_DMA_DONE;
            end
            sagl_pkg::SAGL_DMA_DONE: begin
               if (!dma_en)
                  dma_state_reg <= sagl_pkg::SAGL_DMA_IDLE;
            end
            default: dma_state_reg <= sagl_pkg::SAGL_DMA_IDLE;
         endcase
      end
   end

   // Latches: set wins over the clear from the enable bit
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ack_latch_reg <= 1'b0;
         tc_latch_reg  <= 1'b0;
      end else if (clk_en) begin
         if (ack_rise && dma_state_reg == sagl_pkg::SAGL_DMA_REQ)
            ack_latch_reg <= 1'b1;
         else if (!dma_en)
            ack_latch_reg <= 1'b0;
         if (tc_rise)
            tc_latch_reg <= 1'b1;
         else if (!dma_en)
            tc_latch_reg <= 1'b0;
      end
   end

   // Controller DMA request and interrupt pins deliberately unused
   logic unused_ctl;
   assign unused_ctl = ctl_dma_req_a & ctl_int_n;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         dma_request <= 1'b0;
         dma_channel <= '0;
      end else if (clk_en) begin
         dma_request <= (dma_state_reg == sagl_pkg::SAGL_DMA_REQ)
                        && dma_en && !ack_rise;
         dma_channel <= dma_ctrl_reg[`SAGL_DMA_ENC_LSB +: ENC_W];
      end
   end

   // Divide-by-32 biphase transmit clock
   logic s_ctl_txc_d_reg;
   logic biph_en;
   assign biph_en = p1_ctrl2_reg[`SAGL_CTRL2_BIPH];

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         biph_cnt_reg    <= 5'h00;
         s_ctl_txc_d_reg <= 1'b0;
      end else if (clk_en) begin
         s_ctl_txc_d_reg <= s_ctl_txc;
         if (!biph_en)
            biph_cnt_reg <= 5'h00;
         else if (s_ctl_txc && !s_ctl_txc_d_reg)
            biph_cnt_reg <= biph_cnt_reg + 5'h01;
      end
   end

   // Clock gating toward controller clock pins
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         chan_a_receive_clock_pin <= 1'b0;
         chan_a_tx_clock_in       <= 1'b0;
         chan_b_receive_clock_pin <= 1'b0;
         chan_b_tx_clock_in       <= 1'b0;
         biphase_tx_clock         <= 1'b0;
      end else if (clk_en) begin
         chan_a_receive_clock_pin <= p1_ctrl2_reg[`SAGL_CTRL2_MRXC]
                                     & s_p1_rxc;
         chan_a_tx_clock_in <= p1_ctrl2_reg[`SAGL_CTRL2_MTXC]
                               & s_p1_txc;
         chan_b_receive_clock_pin <= p2_ctrl2_reg[`SAGL_CTRL2_MRXC]
                                     & s_p2_rxc;
         chan_b_tx_clock_in <= p2_ctrl2_reg[`SAGL_CTRL2_MTXC]
                               & s_p2_txc;
         biphase_tx_clock <= biph_en
                             && (biph_cnt_reg > `SAGL_BIPH_HALF);
      end
   end

   // Read data, one cycle after the strobe
   logic [7:0] rdata_next;
   always_comb begin
      unique case (reg_addr)
         `SAGL_OFF_P1_CTRL1: rdata_next = p1_ctrl1_reg;
         `SAGL_OFF_P1_CTRL2: rdata_next = p1_ctrl2_reg;
         `SAGL_OFF_P2_CTRL1: rdata_next = p2_ctrl1_reg;
         `SAGL_OFF_P2_CTRL2: rdata_next = p2_ctrl2_reg;
         // A held strobe returns the capture, not the live lines
         `SAGL_OFF_P1_MODEM: rdata_next = rd_lead ? p1_live : p1_modem_reg;
         `SAGL_OFF_P2_MODEM: rdata_next = rd_lead ? p2_live : p2_modem_reg;
         `SAGL_OFF_DMA_CTRL: rdata_next = dma_ctrl_reg;
         `SAGL_OFF_DMA_STAT: rdata_next = {6'h00, tc_latch_reg,
                                           ack_latch_reg};
         `SAGL_OFF_WRAP:     rdata_next = wrap_reg;
         default:            rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         reg_rdata <= 8'h00;
      else if (clk_en)
         reg_rdata <= reg_rd ? rdata_next : 8'h00;
   end

endmodule

`default_nettype wire

// ### design/sagl_params.svh
// Purpose: Constants of the serial adapter glue logic
// Assumes: Included by the glue logic top module
// Notes:   Offsets are plain-port register indices
`ifndef SAGL_PARAMS_SVH
`define SAGL_PARAMS_SVH

`define SAGL_ADDR_W        4
`define SAGL_OFF_P1_CTRL1  4'h1
`define SAGL_OFF_P1_CTRL2  4'h2
`define SAGL_OFF_P2_CTRL1  4'h3
`define SAGL_OFF_P2_CTRL2  4'h4
`define SAGL_OFF_P1_MODEM  4'h5
`define SAGL_OFF_P2_MODEM  4'h6
`define SAGL_OFF_DMA_CTRL  4'h7
`define SAGL_OFF_DMA_STAT  4'h8
`define SAGL_OFF_WRAP      4'h9

// Interface control register 1/3 fields
`define SAGL_CTRL1_RTS     0
`define SAGL_CTRL1_DTR     1
`define SAGL_CTRL1_RATE    2
`define SAGL_CTRL1_STBY    3
`define SAGL_CTRL1_TEST    4
// Interface control register 2/4 fields
`define SAGL_CTRL2_MRXC    0
`define SAGL_CTRL2_MTXC    1
`define SAGL_CTRL2_BIPH    2
`define SAGL_CTRL2_ACU     7
// DMA control fields
`define SAGL_DMA_ENC_LSB   0
`define SAGL_DMA_ENC_W     3
`define SAGL_DMA_EN        3
// DMA status fields
`define SAGL_DMA_ACK_BIT   0
`define SAGL_DMA_TC_BIT    1
// Wrap register fields
`define SAGL_WRAP_DRV      0
`define SAGL_WRAP_RCV      1

`define SAGL_RESET_BYTE    8'h00
`define SAGL_BIPH_DIV      32
`define SAGL_BIPH_HALF     5'h0f

`endif

// ### design/sagl_pkg.sv
// Purpose: Types of the serial adapter glue logic
// Assumes: Nothing
// Notes:   Constants live in sagl_params.svh
package sagl_pkg;
   typedef enum logic [2:0] {
      SAGL_DMA_IDLE = 3'b001,
      SAGL_DMA_REQ  = 3'b010,
      SAGL_DMA_DONE = 3'b100
   } sagl_dma_state_t;
endpackage

// ### verification/sagl_far_end.sv
// Purpose: Far side model: modem clocks and system DMA controller
// Assumes: Same clock as the glue logic
// Notes:   ack_wait sets how slowly the acknowledge answers
`timescale 1ns/1ns
`default_nettype none

module sagl_far_end (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       dma_request,
   input  wire logic [3:0] ack_wait,
   input  wire logic       tc_on,
   output logic            dma_acknowledge,
   output logic            terminal_count,
   output logic            line_clk,
   output logic            fast_clk
);
   logic [3:0] wait_reg;
   logic [1:0] pulse_reg;
   logic       done_reg;
   logic [2:0] div_reg;

   // One acknowledge per request, two clocks wide
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wait_reg  <= 4'h0;
         pulse_reg <= 2'h0;
         done_reg  <= 1'b0;
      end else if (pulse_reg != 2'h0) begin
         pulse_reg <= pulse_reg - 2'h1;
      end else if (!dma_request) begin
         done_reg <= 1'b0;
         wait_reg <= 4'h0;
      end else if (!done_reg && wait_reg == ack_wait) begin
         pulse_reg <= 2'h2;
         done_reg  <= 1'b1;
      end else if (!done_reg) begin
         wait_reg <= wait_reg + 4'h1;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         div_reg <= 3'h0;
      end else begin
         div_reg <= div_reg + 3'h1;
      end
   end

   assign dma_acknowledge = pulse_reg != 2'h0;
   assign terminal_count  = tc_on && pulse_reg != 2'h0;
   assign fast_clk        = div_reg[1];
   assign line_clk        = div_reg[2];
endmodule

`default_nettype wire

// ### verification/sagl_glue_chk.sv
// Purpose: Port checker of the serial adapter glue logic
// Assumes: Bound to sagl_glue
// Notes:   Tracks port 1 control register 2 from bus writes
`include "sagl_params.svh"
`timescale 1ns/1ns
`default_nettype none

module sagl_glue_chk #(
   parameter int ENC_W = `SAGL_DMA_ENC_W
) (
   input wire logic             clock,
   input wire logic             rst,
   input wire logic [3:0]       reg_addr,
   input wire logic [7:0]       reg_wdata,
   input wire logic             reg_wr,
   input wire logic             reg_rd,
   input wire logic [7:0]       reg_rdata,
   input wire logic             ctl_wr5_rts_p1,
   input wire logic [4:0]       p1_modem_out,
   input wire logic             dma_acknowledge,
   input wire logic             dma_request,
   input wire logic [ENC_W-1:0] dma_channel,
   input wire logic             biphase_tx_clock,
   input wire logic             chan_a_receive_clock_pin
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   logic biph_reg;
   logic gate_reg;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         biph_reg <= 1'b0;
         gate_reg <= 1'b0;
      end else if (reg_wr && reg_addr == `SAGL_OFF_P1_CTRL2) begin
         biph_reg <= reg_wdata[`SAGL_CTRL2_BIPH];
         gate_reg <= reg_wdata[`SAGL_CTRL2_MRXC];
      end
   end

   chk_rdata_idle: assert property (
      !$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read cycle");
   chk_unmapped_zero: assert property (
      reg_rd && reg_addr == 4'hf |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_rts_or: assert property (
      ctl_wr5_rts_p1 [*4] |=> p1_modem_out[0])
      else $error("send request not driven by controller bit");
   chk_req_rise: assert property (
      reg_wr && reg_addr == `SAGL_OFF_DMA_CTRL && reg_wdata[`SAGL_DMA_EN]
      && !dma_request |-> ##[1:3] dma_request)
      else $error("dma request not raised");
   chk_req_drop: assert property (
      $rose(dma_acknowledge) |-> ##[1:4] !dma_request)
      else $error("dma request not dropped on acknowledge");
   chk_chan_map: assert property (
      reg_wr && reg_addr == `SAGL_OFF_DMA_CTRL
      |=> ##1 dma_channel == $past(reg_wdata[ENC_W-1:0], 2))
      else $error("dma channel not from control write");
   chk_biph_idle: assert property (
      !biph_reg && !$past(biph_reg, 4) |-> !biphase_tx_clock)
      else $error("divided clock runs while disabled");
   chk_gate_idle: assert property (
      !gate_reg && !$past(gate_reg, 4) |-> !chan_a_receive_clock_pin)
      else $error("modem clock passed while gated off");
endmodule

bind sagl_glue sagl_glue_chk #(.ENC_W(ENC_W)) u_chk (
   .clock                    (clock),
   .rst                      (rst),
   .reg_addr                 (reg_addr),
   .reg_wdata                (reg_wdata),
   .reg_wr                   (reg_wr),
   .reg_rd                   (reg_rd),
   .reg_rdata                (reg_rdata),
   .ctl_wr5_rts_p1           (ctl_wr5_rts_p1),
   .p1_modem_out             (p1_modem_out),
   .dma_acknowledge          (dma_acknowledge),
   .dma_request              (dma_request),
   .dma_channel              (dma_channel),
   .biphase_tx_clock         (biphase_tx_clock),
   .chan_a_receive_clock_pin (chan_a_receive_clock_pin)
);

`default_nettype wire

// ### verification/sagl_glue_test.sv
// Purpose: Self-checking bench of the serial adapter glue logic
// Assumes: sagl_far_end stands for modem and DMA controller
// Notes:   Reads queue their expected byte; a monitor compares
`include "sagl_params.svh"
`timescale 1ns/1ns
`default_nettype none

module sagl_glue_test;
   logic       clock = 1'b0;
   logic       rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
   logic       wr5_p1 = 1'b0, wr5_p2 = 1'b0, dreq_a = 1'b0, int_n = 1'b1;
   logic [4:0] p1_in = 5'h00, p2_in = 5'h00, acu_in = 5'h00;
   logic       x21_ind = 1'b0, x21_rxd = 1'b0, x21_en = 1'b0, tc_on = 1'b0;
   logic [3:0] ack_wait = 4'h0;
   logic [7:0] reg_rdata;
   logic [4:0] p1_out, p2_out;
   logic [2:0] dma_ch;
   logic       dma_req, rxa, txa, rxb, txb, biph, ack, tc, line_clk, fast_clk;
   logic       acu_sel;
   logic [7:0] exp_q[$];
   int         fail_count = 0, n_compared = 0, cycles = 0;

   sagl_glue dut (
      .clock(clock), .rst(rst), .clk_en(1'b1), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .ctl_wr5_rts_p1(wr5_p1),
      .ctl_wr5_rts_p2(wr5_p2), .ctl_dma_req_a(dreq_a), .ctl_int_n(int_n),
      .p1_modem_in(p1_in), .p2_modem_in(p2_in), .p2_acu_in(acu_in),
      .x21_indicate(x21_ind), .x21_rxd(x21_rxd), .x21_clk_en(x21_en),
      .p1_modem_rxc(line_clk), .p1_modem_txc(line_clk),
      .p2_modem_rxc(line_clk), .p2_modem_txc(line_clk),
      .chan_a_transmit_clock_pin(fast_clk), .dma_acknowledge(ack),
      .terminal_count(tc), .p1_modem_out(p1_out), .p2_modem_out(p2_out),
      .p2_acu_sel(acu_sel), .dma_request(dma_req), .dma_channel(dma_ch),
      .chan_a_receive_clock_pin(rxa), .chan_a_tx_clock_in(txa),
      .chan_b_receive_clock_pin(rxb), .chan_b_tx_clock_in(txb),
      .biphase_tx_clock(biph));

   sagl_far_end far (
      .clock(clock), .rst(rst), .dma_request(dma_req), .ack_wait(ack_wait),
      .tc_on(tc_on), .dma_acknowledge(ack), .terminal_count(tc),
      .line_clk(line_clk), .fast_clk(fast_clk));

   always #5 clock = ~clock;

   task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                        input string what);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic final_report();
      if (fail_count == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      @(posedge clock);
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(posedge clock);
   endtask

   // Read data stand only in the cycle after the strobe
   always @(posedge clock) rd_d <= reg_rd;
   always @(negedge clock) begin
      if (rd_d && exp_q.size() > 0) begin
         check(reg_rdata, exp_q.pop_front(), "read data");
      end
   end

   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         final_report();
      end
   end

   initial begin
      logic [4:0] v;
      logic [7:0] c, k;
      logic [1:0] h;
      int n;
      void'($urandom(32'h3eb9));
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      wr(4'hf, 8'hff);
      rd(4'hf, 8'h00);
      for (int i = 0; i < 4; i++) begin
         v = 5'($urandom);
         p1_in <= v;
         p2_in <= ~v;
         acu_in <= v;
         x21_ind <= v[0];
         dreq_a <= v[1];
         int_n <= v[2];
         repeat (4) @(posedge clock);
         wr(`SAGL_OFF_P1_MODEM, 8'hff);
         rd(`SAGL_OFF_P1_MODEM, {3'h0, ~v});
         rd(`SAGL_OFF_P2_MODEM, {~v[0], 2'h0, v});
      end
      for (int i = 0; i < 4; i++) begin
         c = 8'($urandom) & 8'h1e | 8'(i[0]);
         wr(`SAGL_OFF_P1_CTRL1, c);
         wr(`SAGL_OFF_P2_CTRL1, c);
         wr5_p1 <= i[1];
         wr5_p2 <= i[1];
         repeat (5) @(posedge clock);
         k = {3'h0, c[4:0] | 5'(i[1])};
         check({3'h0, p1_out}, k, "port 1 outputs");
         check({3'h0, p2_out}, k, "port 2 outputs");
      end
      wr5_p1 <= 1'b0;
      for (int i = 1; i < 3; i++) begin
         c = 8'($urandom) & 8'h1f;
         wr(`SAGL_OFF_WRAP, 8'(i));
         wr(`SAGL_OFF_P1_CTRL1, c);
         repeat (4) @(posedge clock);
         rd(`SAGL_OFF_P1_MODEM, {3'h0, ~c[4:0]});
      end
      wr(`SAGL_OFF_WRAP, 8'h00);
      for (int ch = 0; ch < 8; ch++) begin
         ack_wait <= 4'($urandom);
         tc_on <= ch[0];
         wr(`SAGL_OFF_DMA_CTRL, 8'(ch) | 8'h08);
         for (n = 0; dma_req !== 1'b1 && n < 40; n++) @(negedge clock);
         check(8'(dma_req), 8'h01, "dma request raised");
         check({5'h0, dma_ch}, 8'(ch), "dma channel");
         for (n = 0; dma_req !== 1'b0 && n < 40; n++) @(negedge clock);
         check(8'(dma_req), 8'h00, "dma request");
         repeat (3) @(posedge clock);
         rd(`SAGL_OFF_DMA_STAT, {6'h0, ch[0], 1'b1});
         wr(`SAGL_OFF_DMA_CTRL, 8'(ch));
         rd(`SAGL_OFF_DMA_STAT, 8'h00);
      end
      for (int g = 0; g < 2; g++) begin
         wr(`SAGL_OFF_P1_CTRL2, 8'(g * 3));
         wr(`SAGL_OFF_P2_CTRL2, 8'(g * 3));
         repeat (8) @(posedge clock);
         k = 8'h00;
         repeat (64) @(negedge clock) k = k | {4'h0, rxa, txa, rxb, txb};
         check(k, g ? 8'h0f : 8'h00, "gated clocks");
         @(posedge clock);
      end
      wr(`SAGL_OFF_P1_CTRL2, 8'h04);
      repeat (16) @(posedge clock);
      k = 8'h00;
      repeat (`SAGL_BIPH_DIV * 8) @(negedge clock) k = k + biph;
      check(k, 8'(`SAGL_BIPH_DIV * 4), "divided clock");
      @(posedge clock);
      wr(`SAGL_OFF_P1_CTRL2, 8'h00);
      repeat (8) @(posedge clock);
      check(8'(biph), 8'h00, "divided clock idle");
      x21_en <= 1'b1;
      for (int p = 0; p < 3; p++) begin
         repeat (16) begin
            @(negedge line_clk);
            x21_rxd <= (p == 2) ? !x21_rxd : p[0];
         end
         @(posedge line_clk);
         repeat (3) @(posedge clock);
         h = (p == 2) ? {!x21_rxd, x21_rxd} : {2{x21_rxd}};
         rd(`SAGL_OFF_P2_MODEM, {~v[0], h, v});
      end
      x21_en <= 1'b0;
      repeat (6) @(posedge clock);
      rd(`SAGL_OFF_P2_MODEM, {~v[0], 2'h0, v});
      wr(`SAGL_OFF_P2_CTRL2, 8'h80);
      repeat (2) @(posedge clock);
      check(8'(acu_sel), 8'h01, "calling unit select");
      rd(`SAGL_OFF_P2_MODEM, {~v[0], 2'h0, ~v});
      repeat (4) @(posedge clock);
      final_report();
   end
endmodule

`default_nettype wire
